/* ccr2_pkg.sv */
// ccr2_pkg: constants, field layout and carrier types for the charger configuration register two.
// assumes a register access port of the device's management interface (address, write, read strobes).
`default_nettype none

package ccr2_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  CCR2_OFFSET      = 8'h10;
  localparam int          CCR2_WIDTH       = 16;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int          FORCE_GATE_BIT   = 14;
  localparam int          PIN_ROLE_BIT     = 12;
  localparam int          RECHARGE_BIT     = 11;
  localparam int          CELLS_HI_BIT     = 10;
  localparam int          CELLS_LO_BIT     = 9;
  localparam int          IN_SCALE_BIT     = 8;
  localparam int          BAT_SCALE_BIT    = 7;
  localparam int          GATE_EN_BIT      = 6;

  // writable bits; bits 15, 13 and 5:0 are reserved and read as zero
  localparam logic [15:0] CCR2_WMASK       = 16'h5fc0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] CCR2_RESET       = 16'h0a40;
  localparam logic        PIN_ROLE_RESET   = 1'b0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    CCR2_TEMP_SENSE = 2'b01,
    CCR2_CUR_MON    = 2'b10
  } ccr2_pin_role_t;

  // otp-loadable defaults of this register
  typedef struct packed
  {
    logic       valid;
    logic       shared_monitor_pin_role;
    logic       recharge_drop_select;
    logic [1:0] series_cell_count;
    logic       input_sense_scale;
    logic       battery_sense_scale;
  } ccr2_otp_t;

  // decoded configuration handed to the analog side
  typedef struct packed
  {
    logic       force_pass_gate_on;
    logic       pass_gate_driver_enable;
    logic       shared_monitor_pin_role;
    logic       recharge_drop_select;
    logic [1:0] series_cell_count;
    logic       input_sense_scale;
    logic       battery_sense_scale;
  } ccr2_cfg_t;

endpackage

`default_nettype wire

/* ccr2_gate_ctl.sv */
// ccr2_gate_ctl: external pass transistor gate drive decision.
// assumes adapter_ok is an already qualified, clock-synchronous comparator level.
`timescale 1ns/100ps
`default_nettype none

module ccr2_gate_ctl
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // controls
  input  wire logic force_on,
  input  wire logic driver_en,
  input  wire logic adapter_ok,
  // drive
  output var  logic pass_gate_drive
);

  logic drive_d;

  always_comb
  begin
    if (!driver_en)
      drive_d = 1'b0;
    else if (force_on)
      drive_d = 1'b1;
    else
      drive_d = adapter_ok;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pass_gate_drive <= 1'b0;
    else if (clk_en)
      pass_gate_drive <= drive_d;
  end

endmodule // ccr2_gate_ctl

`default_nettype wire

/* ccr2_top.sv */
// ccr2_top: the 16-bit charger configuration register two and its decoded outputs.
// assumes a synchronous register port from the serial management interface and a watchdog expiry pulse.
`timescale 1ns/100ps
`default_nettype none

module ccr2_top
(
  // clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_rd,
  output var  logic [15:0]          reg_rdata,
  output logic                      reg_hit,
  // otp defaults and watchdog
  input  wire ccr2_pkg::ccr2_otp_t  otp_defaults,
  input  wire logic                 host_watchdog_expired,
  // analog side
  input  wire logic                 adapter_sense_voltage_ok,
  output logic                      pass_gate_drive,
  output ccr2_pkg::ccr2_cfg_t       cfg,
  output ccr2_pkg::ccr2_pin_role_t  shared_pin_mode
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [15:0] cfg_q;
  logic        otp_loaded_q;
  logic        wr_hit;

  assign wr_hit  = reg_wr && (reg_addr == ccr2_pkg::CCR2_OFFSET);
  assign reg_hit = (reg_wr || reg_rd) && (reg_addr == ccr2_pkg::CCR2_OFFSET);

  // otp values are taken once after reset release, never inside the async reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      otp_loaded_q <= 1'b0;
    else if (clk_en && otp_defaults.valid)
      otp_loaded_q <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= ccr2_pkg::CCR2_RESET;
    else if (clk_en)
    begin
      if (wr_hit)
        cfg_q <= reg_wdata & ccr2_pkg::CCR2_WMASK;
      else if (!otp_loaded_q && otp_defaults.valid)
      begin
        cfg_q[ccr2_pkg::PIN_ROLE_BIT]                             <= otp_defaults.shared_monitor_pin_role;
        cfg_q[ccr2_pkg::RECHARGE_BIT]                             <= otp_defaults.recharge_drop_select;
        cfg_q[ccr2_pkg::CELLS_HI_BIT:ccr2_pkg::CELLS_LO_BIT]      <= otp_defaults.series_cell_count;
        cfg_q[ccr2_pkg::IN_SCALE_BIT]                             <= otp_defaults.input_sense_scale;
        cfg_q[ccr2_pkg::BAT_SCALE_BIT]                            <= otp_defaults.battery_sense_scale;
      end
      // watchdog wins over a write in the same cycle; only the pin role returns
      if (host_watchdog_expired)
        cfg_q[ccr2_pkg::PIN_ROLE_BIT] <= ccr2_pkg::PIN_ROLE_RESET;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (clk_en && reg_rd)
    begin
      if (reg_addr == ccr2_pkg::CCR2_OFFSET)
        reg_rdata <= cfg_q;
      else
        reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // decoded configuration
  // ----------------------------------------
  always_comb
  begin
    cfg.force_pass_gate_on      = cfg_q[ccr2_pkg::FORCE_GATE_BIT];
    cfg.pass_gate_driver_enable = cfg_q[ccr2_pkg::GATE_EN_BIT];
    cfg.shared_monitor_pin_role = cfg_q[ccr2_pkg::PIN_ROLE_BIT];
    cfg.recharge_drop_select    = cfg_q[ccr2_pkg::RECHARGE_BIT];
    cfg.series_cell_count       = cfg_q[ccr2_pkg::CELLS_HI_BIT:ccr2_pkg::CELLS_LO_BIT];
    cfg.input_sense_scale       = cfg_q[ccr2_pkg::IN_SCALE_BIT];
    cfg.battery_sense_scale     = cfg_q[ccr2_pkg::BAT_SCALE_BIT];
  end

  assign shared_pin_mode = cfg_q[ccr2_pkg::PIN_ROLE_BIT] ? ccr2_pkg::CCR2_CUR_MON
                                                         : ccr2_pkg::CCR2_TEMP_SENSE;

  // ----------------------------------------
  // pass gate
  // ----------------------------------------
  ccr2_gate_ctl u_gate
  (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .force_on        (cfg_q[ccr2_pkg::FORCE_GATE_BIT]),
    .driver_en       (cfg_q[ccr2_pkg::GATE_EN_BIT]),
    .adapter_ok      (adapter_sense_voltage_ok),
    .pass_gate_drive (pass_gate_drive)
  );

endmodule // ccr2_top

`default_nettype wire

/* ccr2_chk.sv */
// ccr2_chk: assertions on the ports of ccr2_top.
// assumes clk_en stays high while resetn is low.
`timescale 1ns/100ps
`default_nettype none
module ccr2_chk
(
  // watched ports
  input wire logic                     core_clk,
  input wire logic                     resetn,
  input wire logic                     clk_en,
  input wire logic [7:0]               reg_addr,
  input wire logic                     reg_wr,
  input wire logic [15:0]              reg_wdata,
  input wire logic                     host_watchdog_expired,
  input wire logic                     adapter_sense_voltage_ok,
  input wire logic                     pass_gate_drive,
  input wire ccr2_pkg::ccr2_cfg_t      cfg,
  input wire ccr2_pkg::ccr2_pin_role_t shared_pin_mode
);
  // ----
  // helpers
  // ----
  // the internal reset copy lags resetn by two edges, so wait three
  logic [1:0]  up_q;
  logic [15:0] wd_q;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  always_ff @(posedge core_clk)
    wd_q <= reg_wdata;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_up;
    clk_en && up_q == 2'h3;
  endsequence
  sequence s_wr;
    s_up ##0 reg_wr && reg_addr == ccr2_pkg::CCR2_OFFSET;
  endsequence
  property p_force;
    s_up ##0 cfg.pass_gate_driver_enable && cfg.force_pass_gate_on |=> pass_gate_drive;
  endproperty
  property p_follow;
    s_up ##0 cfg.pass_gate_driver_enable && !cfg.force_pass_gate_on |=> pass_gate_drive == $past(adapter_sense_voltage_ok);
  endproperty
  property p_off;
    clk_en && !cfg.pass_gate_driver_enable |=> !pass_gate_drive;
  endproperty
  property p_role;
    shared_pin_mode == (cfg.shared_monitor_pin_role ? ccr2_pkg::CCR2_CUR_MON : ccr2_pkg::CCR2_TEMP_SENSE);
  endproperty
  property p_wdog;
    s_up ##0 host_watchdog_expired |=> !cfg.shared_monitor_pin_role;
  endproperty
  property p_rech;
    s_wr |=> cfg.recharge_drop_select == wd_q[11];
  endproperty
  property p_cells;
    s_wr |=> cfg.series_cell_count == wd_q[10:9];
  endproperty
  property p_insc;
    s_wr |=> cfg.input_sense_scale == wd_q[8];
  endproperty
  a_force: assert property (p_force)
    else $error("forced gate not driven");
  a_follow: assert property (p_follow)
    else $error("gate does not follow adapter");
  a_off: assert property (p_off)
    else $error("gate driven while disabled");
  a_role: assert property (p_role)
    else $error("pin role decode wrong");
  a_wdog: assert property (p_wdog)
    else $error("pin role kept on watchdog");
  a_rech: assert property (p_rech)
    else $error("recharge bit wrong");
  a_cells: assert property (p_cells)
    else $error("cell count wrong");
  a_insc: assert property (p_insc)
    else $error("input scale wrong");
endmodule // ccr2_chk
bind ccr2_top ccr2_chk u_chk (.core_clk, .resetn, .clk_en, .reg_addr, .reg_wr, .reg_wdata,
  .host_watchdog_expired, .adapter_sense_voltage_ok, .pass_gate_drive, .cfg, .shared_pin_mode);
`default_nettype wire

/* ccr2_tb.sv */
// testbench: directed scenarios for ccr2_top over its register port.
// assumes the checker is bound in from its own file.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk, resetn, reg_wr, reg_rd, wdog, adapter_sense_voltage, reg_hit, drv, clk_en;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  ccr2_pkg::ccr2_otp_t otp;
  ccr2_pkg::ccr2_cfg_t cfg;
  ccr2_pkg::ccr2_pin_role_t pmode;
  int error_cnt = 0;
  int cmp_count = 0;
  ccr2_top uut (.core_clk, .resetn, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_hit, .otp_defaults(otp), .host_watchdog_expired(wdog), .adapter_sense_voltage_ok(adapter_sense_voltage),
    .pass_gate_drive(drv), .cfg, .shared_pin_mode(pmode));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic do_reset;
    resetn = 1'b0;
    cyc(3);
    resetn = 1'b1;
    cyc(3);
  endtask
  task automatic wr(input logic [15:0] d);
    reg_addr = ccr2_pkg::CCR2_OFFSET;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    #1 chk({15'h0000, reg_hit}, {15'h0000, a == ccr2_pkg::CCR2_OFFSET});
    cyc(1);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  task automatic t_fields;
    rd(8'h10, 16'h0a40);
    chk({14'h0000, pmode}, 16'h0001);
    wr(16'h5fc0);
    rd(8'h10, 16'h5fc0);
    chk({14'h0000, pmode}, 16'h0002);
    chk({8'h00, cfg}, 16'h00ff);
    for (int i = 0; i < 4; i++)
    begin
      wr(16'h0180 | (16'(i) << 9));
      rd(8'h10, 16'h0180 | (16'(i) << 9));
    end
    cyc(1);
    rd(8'h11, 16'h0000);
    $display("fields test done");
  endtask
  task automatic t_gate;
    wr(16'h0040);
    adapter_sense_voltage = 1'b1;
    cyc(2);
    chk({15'h0000, drv}, 16'h0001);
    adapter_sense_voltage = 1'b0;
    cyc(2);
    chk({15'h0000, drv}, 16'h0000);
    wr(16'h4040);
    cyc(2);
    chk({15'h0000, drv}, 16'h0001);
    adapter_sense_voltage = 1'b1;
    wr(16'h4000);
    cyc(2);
    chk({15'h0000, drv}, 16'h0000);
    $display("gate test done");
  endtask
  task automatic t_wdog;
    wr(16'h1a40);
    wdog = 1'b1;
    cyc(1);
    wdog = 1'b0;
    rd(8'h10, 16'h0a40);
    $display("watchdog test done");
  endtask
  task automatic t_freeze;
    clk_en = 1'b0;
    wr(16'h4000);
    clk_en = 1'b1;
    cyc(1);
    rd(8'h10, 16'h0a40);
    $display("freeze test done");
  endtask
  task automatic t_otp;
    otp = 7'h6f;
    do_reset();
    rd(8'h10, 16'h17c0);
    $display("otp test done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    {resetn, reg_wr, reg_rd, wdog, adapter_sense_voltage, reg_addr, reg_wdata, otp} = '0;
    clk_en = 1'b1;
    do_reset();
    t_fields();
    t_gate();
    t_wdog();
    t_freeze();
    t_otp();
    final_report();
  end
endmodule // testbench
`default_nettype wire
